// ### design/dcf_device.sv
// Purpose: two opposite 256 x 36 queues with port-synchronised flags
// Assumes: port clocks coincident, both are clock_i
// Notes: mailbox path left out; mailbox-select high blocks queue access
`timescale 1ns/1ps
`include "dcf_consts.svh"

module dcf_queue (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic [35:0] wdata_i,
  input wire logic rd_i,
  input wire logic [7:0] x_i,
  input wire logic [7:0] y_i,
  output logic ir_o,
  output logic or_o,
  output logic ae_o,
  output logic af_o,
  output logic [35:0] q_o
);
  logic [35:0] mem_q [256];
  logic [8:0] wptr_q;
  logic [8:0] wptr_d;
  logic [8:0] rptr_q;
  logic [8:0] rptr_d;
  logic [8:0] wsync1_q;
  logic [8:0] wsync2_q;
  logic [8:0] rsync1_q;
  logic [8:0] rsync2_q;
  logic [8:0] count_w;
  logic [8:0] count_r;
  logic wr_ok;
  logic load;

  // gated strobes; an unready flag leaves pointers alone
  assign wr_ok = wr_i & ir_o;
  assign load = (~or_o | (rd_i & or_o)) & (wsync2_q != rptr_q);
  assign wptr_d = wptr_q + {8'h00, wr_ok};
  assign rptr_d = rptr_q + {8'h00, load};
  // next-state fill levels, so a flag never lags its own side's move
  assign count_w = wptr_d - rsync2_q;
  assign count_r = wsync2_q - rptr_d;

  // memory has no reset: contents are don't-care until written
  always_ff @(posedge clock_i)
  begin
    if (ce_i && wr_ok)
    begin
      mem_q[wptr_q[7:0]] <= wdata_i;
    end
  end

  // write side: pointer and read-pointer synchroniser
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      wptr_q <= 9'h000;
      rsync1_q <= 9'h000;
      rsync2_q <= 9'h000;
    end
    else if (ce_i)
    begin
      wptr_q <= wptr_d;
      rsync1_q <= rptr_q;
      rsync2_q <= rsync1_q;
    end
  end

  // write-side flags; coincident edges fall inside the skew window
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      ir_o <= 1'b0;
      af_o <= 1'b0;
    end
    else if (ce_i)
    begin
      ir_o <= count_w != `DCF_DEPTH;
      af_o <= count_w < (`DCF_DEPTH - {1'b0, y_i});
    end
  end

  // read side: write-pointer synchroniser
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      wsync1_q <= 9'h000;
      wsync2_q <= 9'h000;
    end
    else if (ce_i)
    begin
      wsync1_q <= wptr_q;
      wsync2_q <= wsync1_q;
    end
  end

  // output register: word falls through on third edge after write
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      rptr_q <= 9'h000;
      or_o <= 1'b0;
      q_o <= 36'h0_0000_0000;
    end
    else if (ce_i)
    begin
      rptr_q <= rptr_d;
      if (load)
      begin
        q_o <= mem_q[rptr_q[7:0]];
        or_o <= 1'b1;
      end
      else if (rd_i)
      begin
        or_o <= 1'b0;
      end
    end
  end

  // almost-empty follows the synchronised write pointer
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      ae_o <= 1'b0;
    end
    else if (ce_i)
    begin
      ae_o <= count_r > {1'b0, x_i};
    end
  end
endmodule

module dcf_device (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  dcf_if.dev pins
);
  logic sel_a;
  logic sel_b;
  logic a_wr;
  logic a_rd;
  logic b_wr;
  logic b_rd;
  logic [1:0] prog_idx_q;
  logic [7:0] x1_q;
  logic [7:0] y1_q;
  logic [7:0] x2_q;
  logic [7:0] y2_q;
  logic a_oe_q;
  logic b_oe_q;

  // port decode; mailbox-select high never touches a queue
  assign sel_a = pins.port_a_enable & ~pins.port_a_chip_select_n & ~pins.port_a_mailbox_sel;
  assign sel_b = pins.port_b_enable & ~pins.port_b_chip_select_n & ~pins.port_b_mailbox_sel;
  assign a_wr = sel_a & pins.port_a_write_read_sel & ~pins.offset_prog;
  assign a_rd = sel_a & ~pins.port_a_write_read_sel;
  assign b_rd = sel_b & pins.port_b_write_read_sel;
  assign b_wr = sel_b & ~pins.port_b_write_read_sel;

  // offset words x1, y1, x2, y2 in turn; index holds across gaps
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      prog_idx_q <= 2'h0;
      x1_q <= `DCF_OFS_RST;
      y1_q <= `DCF_OFS_RST;
      x2_q <= `DCF_OFS_RST;
      y2_q <= `DCF_OFS_RST;
    end
    else if (ce_i && pins.offset_prog && sel_a && pins.port_a_write_read_sel)
    begin
      prog_idx_q <= prog_idx_q + 2'h1;
      case (prog_idx_q)
        2'h0: x1_q <= pins.port_a_bus_in[7:0];
        2'h1: y1_q <= pins.port_a_bus_in[7:0];
        2'h2: x2_q <= pins.port_a_bus_in[7:0];
        default: y2_q <= pins.port_a_bus_in[7:0];
      endcase
    end
  end

  // bus drive follows the select one edge late, keeping outputs registered
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      a_oe_q <= 1'b0;
      b_oe_q <= 1'b0;
    end
    else if (ce_i)
    begin
      a_oe_q <= ~pins.port_a_chip_select_n & ~pins.port_a_write_read_sel;
      b_oe_q <= ~pins.port_b_chip_select_n & pins.port_b_write_read_sel;
    end
  end
  assign pins.port_a_bus_oe = a_oe_q;
  assign pins.port_b_bus_oe = b_oe_q;

  // a-to-b queue: written by port a, read by port b
  dcf_queue u_a_to_b_queue (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .wr_i(a_wr),
    .wdata_i(pins.port_a_bus_in),
    .rd_i(b_rd),
    .x_i(x1_q),
    .y_i(y1_q),
    .ir_o(pins.input_ready_a),
    .or_o(pins.output_ready_b),
    .ae_o(pins.almost_empty_b),
    .af_o(pins.almost_full_a),
    .q_o(pins.port_b_bus_out)
  );

  // b-to-a queue: written by port b, read by port a
  dcf_queue u_b_to_a_queue (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .wr_i(b_wr),
    .wdata_i(pins.port_b_bus_in),
    .rd_i(a_rd),
    .x_i(x2_q),
    .y_i(y2_q),
    .ir_o(pins.input_ready_b),
    .or_o(pins.output_ready_a),
    .ae_o(pins.almost_empty_a),
    .af_o(pins.almost_full_b),
    .q_o(pins.port_a_bus_out)
  );
endmodule

// ### design/dcf_host.sv
// Purpose: both port masters, commanded over an AXI4-Lite slave
// Assumes: same clock as the device
// Notes: one command at a time; waits on the ready flag, no timeout
`timescale 1ns/1ps
`include "dcf_consts.svh"

module dcf_host (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  dcf_if.host pins
);
  dcf_pkg::dcf_st_e st_q;
  dcf_pkg::dcf_op_e op_q;
  logic prog_q;
  logic [35:0] wd_q;
  logic [35:0] rd_q;
  logic go;
  logic wr_take;
  logic flag_ok;

  // take address and data together, one write in flight
  assign wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
  assign go = wr_take & (s_axi_awaddr == `DCF_REG_CMD) & s_axi_wstrb[0] & (st_q == dcf_pkg::DCF_ST_IDLE);
  assign flag_ok = (op_q == dcf_pkg::DCF_OP_A_WR) ? (pins.input_ready_a | prog_q) :
                   (op_q == dcf_pkg::DCF_OP_A_RD) ? pins.output_ready_a :
                   (op_q == dcf_pkg::DCF_OP_B_WR) ? pins.input_ready_b : pins.output_ready_b;

  // write channel and registers; a command while busy is dropped
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      wd_q <= 36'h0_0000_0000;
    end
    else if (ce_i)
    begin
      s_axi_awready <= wr_take;
      s_axi_wready <= wr_take;
      if (wr_take)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (s_axi_awaddr == `DCF_REG_CMD || s_axi_awaddr == `DCF_REG_WLO ||
                        s_axi_awaddr == `DCF_REG_WHI) ? 2'b00 : 2'b10;
        if (s_axi_awaddr == `DCF_REG_WLO)
        begin
          wd_q[31:0] <= s_axi_wdata;
        end
        if (s_axi_awaddr == `DCF_REG_WHI)
        begin
          wd_q[35:32] <= s_axi_wdata[3:0];
        end
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: answer on the same edge that raises arready
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else if (ce_i)
    begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `DCF_REG_CMD: s_axi_rdata <= {29'h0000_0000, prog_q, op_q};
          `DCF_REG_WLO: s_axi_rdata <= wd_q[31:0];
          `DCF_REG_WHI: s_axi_rdata <= {28'h000_0000, wd_q[35:32]};
          `DCF_REG_RLO: s_axi_rdata <= rd_q[31:0];
          `DCF_REG_RHI: s_axi_rdata <= {28'h000_0000, rd_q[35:32]};
          `DCF_REG_STAT: s_axi_rdata <= {23'h00_0000, st_q != dcf_pkg::DCF_ST_IDLE,
            pins.almost_full_b, pins.almost_empty_b, pins.output_ready_b, pins.input_ready_b,
            pins.almost_full_a, pins.almost_empty_a, pins.output_ready_a, pins.input_ready_a};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // port sequencer: select, wait for flag, one enabled edge
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      st_q <= dcf_pkg::DCF_ST_IDLE;
      op_q <= dcf_pkg::DCF_OP_A_WR;
      prog_q <= 1'b0;
      rd_q <= 36'h0_0000_0000;
      pins.port_a_chip_select_n <= 1'b1;
      pins.port_a_write_read_sel <= 1'b1;
      pins.port_a_enable <= 1'b0;
      pins.port_b_chip_select_n <= 1'b1;
      pins.port_b_write_read_sel <= 1'b0;
      pins.port_b_enable <= 1'b0;
      pins.port_a_bus_in <= 36'h0_0000_0000;
      pins.port_b_bus_in <= 36'h0_0000_0000;
      pins.offset_prog <= 1'b0;
      // mailbox path unused: selects held low by their flops from reset
      pins.port_a_mailbox_sel <= 1'b0;
      pins.port_b_mailbox_sel <= 1'b0;
    end
    else if (ce_i)
    begin
      pins.port_a_enable <= 1'b0;
      pins.port_b_enable <= 1'b0;
      case (st_q)
        dcf_pkg::DCF_ST_IDLE:
        begin
          if (go)
          begin
            op_q <= dcf_pkg::dcf_op_e'(s_axi_wdata[1:0]);
            prog_q <= s_axi_wdata[`DCF_CMD_PROG];
            st_q <= dcf_pkg::DCF_ST_SETUP;
          end
        end
        dcf_pkg::DCF_ST_SETUP:
        begin
          // a write: dir high a read: dir low
          pins.port_a_chip_select_n <= op_q[1];
          pins.port_a_write_read_sel <= (op_q == dcf_pkg::DCF_OP_A_WR);
          // b read: dir high b write: dir low
          pins.port_b_chip_select_n <= ~op_q[1];
          pins.port_b_write_read_sel <= (op_q == dcf_pkg::DCF_OP_B_RD);
          pins.port_a_bus_in <= wd_q;
          pins.port_b_bus_in <= wd_q;
          pins.offset_prog <= prog_q & (op_q == dcf_pkg::DCF_OP_A_WR);
          st_q <= dcf_pkg::DCF_ST_WAIT;
        end
        dcf_pkg::DCF_ST_WAIT:
        begin
          // flag seen now, so the enabled edge is the next one
          if (flag_ok)
          begin
            pins.port_a_enable <= ~op_q[1];
            pins.port_b_enable <= op_q[1];
            if (op_q == dcf_pkg::DCF_OP_A_RD)
            begin
              rd_q <= pins.port_a_bus_out;
            end
            if (op_q == dcf_pkg::DCF_OP_B_RD)
            begin
              rd_q <= pins.port_b_bus_out;
            end
            st_q <= dcf_pkg::DCF_ST_IDLE;
          end
        end
        default:
        begin
          st_q <= dcf_pkg::DCF_ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ### dv/dcf_flag_asserts.sv
// Purpose: flag timing checks on the link between the two ends
// Assumes: both ports on clock_i, ce_i held high, mailbox selects low
// Notes: latencies counted in edges after the taking edge
`timescale 1ns/1ps
module dcf_flag_asserts (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic port_a_chip_select_n,
  input wire logic port_a_write_read_sel,
  input wire logic port_a_enable,
  input wire logic port_b_chip_select_n,
  input wire logic port_b_write_read_sel,
  input wire logic port_b_enable,
  input wire logic offset_prog,
  input wire logic input_ready_a,
  input wire logic output_ready_a,
  input wire logic almost_full_a,
  input wire logic input_ready_b,
  input wire logic output_ready_b,
  input wire logic almost_empty_b
);
  logic wa;
  logic ra;
  logic wb;
  logic rb;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // queue transfers the device may take; offset loads are not queue writes
  assign wa = port_a_enable & ~port_a_chip_select_n & port_a_write_read_sel
    & input_ready_a & ~offset_prog;
  assign ra = port_a_enable & ~port_a_chip_select_n & ~port_a_write_read_sel & output_ready_a;
  assign wb = port_b_enable & ~port_b_chip_select_n & ~port_b_write_read_sel & input_ready_b;
  assign rb = port_b_enable & ~port_b_chip_select_n & port_b_write_read_sel & output_ready_b;
  // flag set on the third edge after the taking edge is first sampled high on the fourth
  b_fall_thru_a : assert property (wa && !output_ready_b |-> ##[1:4] output_ready_b)
    else $error("b output-ready late after write into empty queue");
  a_fall_thru_a : assert property (wb && !output_ready_a |-> ##[1:4] output_ready_a)
    else $error("a output-ready late after write into empty queue");
  a_space_back_a : assert property (rb && !input_ready_a |-> ##[1:4] input_ready_a)
    else $error("a input-ready not back after read of full queue");
  b_space_back_a : assert property (ra && !input_ready_b |-> ##[1:4] input_ready_b)
    else $error("b input-ready not back after read of full queue");
  b_fill_rise_a : assert property ($rose(almost_empty_b) |-> $past(wa, 4))
    else $error("b almost-empty rose without write four edges before");
  a_room_rise_a : assert property (
    $rose(almost_full_a) && $past(nrst_i, 3) |-> $past(rb, 3) || $past(rb, 4))
    else $error("a almost-full rose without a b read before it");
  b_word_drop_a : assert property ($fell(output_ready_b) |-> $past(rb))
    else $error("b output-ready fell without a read");
  a_space_drop_a : assert property ($fell(input_ready_a) |-> $past(wa))
    else $error("a input-ready fell without a write");
endmodule

// ### dv/dual_clock_fifo_flag_sync_tb_top.sv
// Purpose: drives both queues through the host register bus
// Assumes: one clock, ce_i held high, full strobes
// Notes: flags are read back from the status register
`timescale 1ns/1ps
`include "dcf_consts.svh"
module dual_clock_fifo_flag_sync_tb_top;
  logic clock_i;
  logic nrst_i;
  logic [7:0] awaddr;
  logic [7:0] araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] stat_v;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int n_fail = 0;
  int check_count = 0;
  int ofs[4] = '{2, 250, 1, 254};
  dcf_if bus ();
  dcf_device dcf_device_inst (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(1'h1), .pins(bus));
  dcf_host dcf_host_inst (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(1'h1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pins(bus));
  dcf_flag_asserts dcf_flag_asserts_inst (.clock_i(clock_i), .nrst_i(nrst_i),
    .port_a_chip_select_n(bus.port_a_chip_select_n),
    .port_a_write_read_sel(bus.port_a_write_read_sel), .port_a_enable(bus.port_a_enable),
    .port_b_chip_select_n(bus.port_b_chip_select_n),
    .port_b_write_read_sel(bus.port_b_write_read_sel), .port_b_enable(bus.port_b_enable),
    .offset_prog(bus.offset_prog), .input_ready_a(bus.input_ready_a),
    .output_ready_a(bus.output_ready_a), .almost_full_a(bus.almost_full_a),
    .input_ready_b(bus.input_ready_b), .output_ready_b(bus.output_ready_b),
    .almost_empty_b(bus.almost_empty_b));
  // free-running 100 MHz clock
  initial
  begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic results();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // a wait that ran out ends the run at once
  task automatic tmo(input int n);
    if (n >= 200)
    begin
      n_fail++;
      $display("FAIL wait exp done seen timeout");
      results();
    end
  endtask
  // one write; an edge passes after release so the next call never overlaps
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 200);
    bready <= 1'h0;
    @(posedge clock_i);
    tmo(n);
    chk("bresp", 36'(bresp), 36'(er));
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
      if (arready)
        arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 200);
    d = rdata;
    rready <= 1'h0;
    @(posedge clock_i);
    tmo(n);
    chk("rresp", 36'(rresp), 36'(er));
  endtask
  // commands are refused while busy, so wait for it to clear
  task automatic idle();
    int n;
    n = 0;
    do
    begin
      axi_rd(`DCF_REG_STAT, stat_v, 2'h0);
      n++;
    end while (stat_v[`DCF_STAT_BUSY] !== 1'h0 && n < 200);
    tmo(n);
  endtask
  task automatic put(input logic [2:0] op, input logic [35:0] w);
    axi_wr(`DCF_REG_WLO, w[31:0], 2'h0);
    axi_wr(`DCF_REG_WHI, {28'h0, w[35:32]}, 2'h0);
    axi_wr(`DCF_REG_CMD, {29'h0, op}, 2'h0);
    idle();
  endtask
  task automatic get(input logic [2:0] op, output logic [35:0] d);
    logic [31:0] lo;
    logic [31:0] hi;
    axi_wr(`DCF_REG_CMD, {29'h0, op}, 2'h0);
    idle();
    axi_rd(`DCF_REG_RLO, lo, 2'h0);
    axi_rd(`DCF_REG_RHI, hi, 2'h0);
    d = {hi[3:0], lo};
  endtask
  // tot words queued; the output-register word no longer counts as stored
  task automatic flags(input int tot, input int wb, input int rb, input int x, input int y);
    int m;
    m = (tot > 0) ? tot - 1 : 0;
    repeat (4) @(posedge clock_i);
    axi_rd(`DCF_REG_STAT, stat_v, 2'h0);
    chk("input_ready", 36'(stat_v[wb]), 36'(m < 256));
    chk("output_ready", 36'(stat_v[rb + 1]), 36'(tot > 0));
    chk("almost_empty", 36'(stat_v[rb + 2]), 36'(m > x));
    chk("almost_full", 36'(stat_v[wb + 3]), 36'(m < 256 - y));
  endtask
  // fill until input-ready drops, then drain in order
  task automatic flow(input logic [2:0] wop, input logic [2:0] rop, input int wb, input int rb,
    input int x, input int y);
    int n;
    logic [35:0] d;
    n = 0;
    do
    begin
      put(wop, 36'h5a0000000 + 36'(n));
      n++;
      flags(n, wb, rb, x, y);
    end while (stat_v[wb] === 1'h1 && n < 300);
    chk("fill_count", 36'(n), 36'h101);
    for (int k = 0; k < n; k++)
    begin
      get(rop, d);
      chk("word", d, 36'h5a0000000 + 36'(k));
      // selects stay on after a read, so the reading port still drives its bus
      chk("read_oe", 36'((rb == 4) ? bus.port_b_bus_oe : bus.port_a_bus_oe),
        36'h1);
      flags(n - 1 - k, wb, rb, x, y);
    end
  endtask
  // main sequence
  initial
  begin
    nrst_i = 1'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    awvalid = 1'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    arvalid = 1'h0;
    rready = 1'h0;
    repeat (5) @(posedge clock_i);
    nrst_i <= 1'h1;
    @(posedge clock_i);
    flags(0, 0, 4, 8, 8);
    flags(0, 4, 0, 8, 8);
    axi_rd(8'h18, stat_v, 2'h2);
    chk("unmapped", 36'(stat_v), 36'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      put(3'h4, 36'(ofs[i]));
      repeat (3 + i) @(posedge clock_i);
    end
    $display("test offsets done");
    flow({1'h0, dcf_pkg::DCF_OP_A_WR}, {1'h0, dcf_pkg::DCF_OP_B_RD}, 0, 4, 2, 250);
    $display("test a_to_b done");
    flow({1'h0, dcf_pkg::DCF_OP_B_WR}, {1'h0, dcf_pkg::DCF_OP_A_RD}, 4, 0, 1, 254);
    $display("test b_to_a done");
    results();
  end
endmodule

// ### include/dcf_consts.svh
// Purpose: shared numbers of the two-queue flag block
// Assumes: one 100 MHz clock drives both ports
// Notes: offsets in bytes on the host register bus
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH
`define DCF_WORD_W 36
`define DCF_PTR_W 9
`define DCF_DEPTH 9'h100
`define DCF_OFS_W 8
`define DCF_OFS_RST 8'h08
`define DCF_REG_CMD 8'h00
`define DCF_REG_WLO 8'h04
`define DCF_REG_WHI 8'h08
`define DCF_REG_RLO 8'h0c
`define DCF_REG_RHI 8'h10
`define DCF_REG_STAT 8'h14
`define DCF_CMD_PROG 2
`define DCF_STAT_BUSY 8
`endif

// ### include/dcf_if.sv
// Purpose: pins between the queue device and the two port masters
// Assumes: both ports run on the same clock
// Notes: each data bus is split into in, out and output enable
`timescale 1ns/1ps
interface dcf_if;
  logic port_a_chip_select_n;
  logic port_a_write_read_sel;
  logic port_a_mailbox_sel;
  logic port_a_enable;
  logic [35:0] port_a_bus_in;
  logic [35:0] port_a_bus_out;
  logic port_a_bus_oe;
  logic port_b_chip_select_n;
  logic port_b_write_read_sel;
  logic port_b_mailbox_sel;
  logic port_b_enable;
  logic [35:0] port_b_bus_in;
  logic [35:0] port_b_bus_out;
  logic port_b_bus_oe;
  logic offset_prog;
  logic input_ready_a;
  logic output_ready_a;
  logic almost_empty_a;
  logic almost_full_a;
  logic input_ready_b;
  logic output_ready_b;
  logic almost_empty_b;
  logic almost_full_b;
  modport dev (
    input port_a_chip_select_n, port_a_write_read_sel, port_a_mailbox_sel, port_a_enable,
    input port_a_bus_in, port_b_bus_in, offset_prog,
    input port_b_chip_select_n, port_b_write_read_sel, port_b_mailbox_sel, port_b_enable,
    output port_a_bus_out, port_a_bus_oe, port_b_bus_out, port_b_bus_oe,
    output input_ready_a, output_ready_a, almost_empty_a, almost_full_a,
    output input_ready_b, output_ready_b, almost_empty_b, almost_full_b
  );
  modport host (
    output port_a_chip_select_n, port_a_write_read_sel, port_a_mailbox_sel, port_a_enable,
    output port_a_bus_in, port_b_bus_in, offset_prog,
    output port_b_chip_select_n, port_b_write_read_sel, port_b_mailbox_sel, port_b_enable,
    input port_a_bus_out, port_a_bus_oe, port_b_bus_out, port_b_bus_oe,
    input input_ready_a, output_ready_a, almost_empty_a, almost_full_a,
    input input_ready_b, output_ready_b, almost_empty_b, almost_full_b
  );
endinterface

// ### include/dcf_pkg.sv
// Purpose: types shared by the host and the testbench
// Assumes: nothing
// Notes: op codes match the command register op field
package dcf_pkg;
  typedef enum logic [1:0] {
    DCF_OP_A_WR = 2'b00,
    DCF_OP_A_RD = 2'b01,
    DCF_OP_B_WR = 2'b10,
    DCF_OP_B_RD = 2'b11
  } dcf_op_e;
  typedef enum logic [1:0] {
    DCF_ST_IDLE = 2'b00,
    DCF_ST_SETUP = 2'b01,
    DCF_ST_WAIT = 2'b10
  } dcf_st_e;
endpackage
